// ==== src/sfph_pkg.sv ====
/*
 * Package for the serial flash protect and hold block: command opcodes,
 * configuration bit positions, status bit positions, geometry and reset values.
 * Assumes a single-lane SPI front end sampled on core_clk.
 */
//
// Contract
// - write enable command sets the latch
// - latch cleared at reset and modifying-command end; code clears it only when the command executes, a refused one keeps it
// - protected area readable, program/erase refused
// - top start: code n guards top 2^n sectors; code 0 guards none
// - bottom start: code n guards low 2^n sectors; code 0 guards none
// - protect pin plus disable bit form hardware mode; code also needs quad mode off
// - hardware mode freezes disable and protect bits
// - modifying command needs whole-byte clock count
// - hold pauses bus only, operations continue
// - hold entry on pin fall with clock low
// - hold exit on pin rise with clock low
// - in hold: output floats, input and clock ignored
// - deselect during hold resets serial logic
// - quad bit disables hold function
// - config bit 5 picks protect start
// - config bit 1 selects quad mode
package sfph_pkg;
    // ----------------------------------------------------------------
    // command opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] SFPH_OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] SFPH_OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] SFPH_OP_REGISTER_WRITE = 8'h01;
    localparam logic [7:0] SFPH_OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] SFPH_OP_QUAD_PAGE_PROGRAM = 8'h32;
    localparam logic [7:0] SFPH_OP_SECTOR_ERASE = 8'hD8;
    localparam logic [7:0] SFPH_OP_BULK_ERASE = 8'hC7;
    localparam logic [7:0] SFPH_OP_PARAM_SMALL_ERASE = 8'h20;
    localparam logic [7:0] SFPH_OP_PARAM_DOUBLE_ERASE = 8'h40;
    localparam logic [7:0] SFPH_OP_OTP_BYTE_PROGRAM = 8'h42;
    // ----------------------------------------------------------------
    // register fields and geometry
    // ----------------------------------------------------------------
    localparam int SFPH_CFG_QUAD_BIT = 1;
    localparam int SFPH_CFG_PROT_START_BIT = 5;
    localparam int SFPH_ST_BP_LSB = 2;
    localparam int SFPH_ST_SWD_BIT = 7;
    localparam int SFPH_ADDR_W = 23;
    localparam int SFPH_SECTOR_LSB = 16;
    localparam logic [2:0] SFPH_BP_NONE = 3'h0;
    localparam logic [2:0] SFPH_BP_ALL = 3'h7;
    localparam logic [7:0] SFPH_CFG_RESET = 8'h00;
    localparam logic [7:0] SFPH_ST_RESET = 8'h00;
    localparam logic [2:0] SFPH_BIT_LAST = 3'h7;
    // ----------------------------------------------------------------
    // front end states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {SFPH_OPCODE, SFPH_ADDRESS, SFPH_PAYLOAD, SFPH_DONE} sfph_phase_t;
endpackage

// ==== src/sfph_protect_map.sv ====
/*
 * Sector protection decode: tells whether a 64 kB sector number lies in the
 * area guarded by the block-protect code. Pure combinational, no clock.
 */
`timescale 1ns/1ps
module sfph_protect_map (
    input wire logic [2:0] block_protect,
    input wire logic protect_start_select,
    input wire logic [6:0] sector,
    output logic is_protected
);
    // code n of 1 to 7 guards 2^n sectors; 0 guards none, 7 guards the full array
    logic [7:0] span;
    logic [6:0] from_top;
    logic in_span;
    assign span = (block_protect == sfph_pkg::SFPH_BP_ALL) ? 8'h80 : (8'h01 << block_protect);
    assign from_top = 7'h7F - sector;
    assign in_span = protect_start_select ? ({1'b0, sector} < span) : ({1'b0, from_top} < span);
    assign is_protected = (block_protect != sfph_pkg::SFPH_BP_NONE) && in_span;
endmodule

// ==== src/sfph_core.sv ====
/*
 * Protect and hold logic of a serial NOR flash: write enable latch,
 * block protection, hardware status lock, byte-count check and hold mode.
 * Assumes SPI mode 0 pins arrive asynchronously; the array engine outside
 * executes exec_* pulses and reports busy.
 */
`timescale 1ns/1ps
module sfph_core (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic hold_n,
    input wire logic write_protect_pin,
    input wire logic [7:0] cfg_in,
    input wire logic engine_busy,
    output logic so_out,
    output logic so_oe,
    output logic write_enable_latch,
    output logic status_write_disable,
    output logic [2:0] block_protect,
    output logic hardware_protection_mode,
    output logic hold_active,
    output logic exec_valid,
    output logic [7:0] exec_opcode,
    output logic [22:0] exec_addr,
    output logic cmd_rejected
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [4:0] s1_r, s2_r;
    logic sck_d_r;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            // pins at idle, sck low, so no false clock edge follows reset
            s1_r <= 5'h17;
            s2_r <= 5'h17;
            sck_d_r <= 1'b0;
        end else begin
            s1_r <= {cs_n, sck, si, hold_n, write_protect_pin};
            s2_r <= s1_r;
            sck_d_r <= s2_r[3];
        end
    end
    wire cs_n_s = s2_r[4];
    wire sck_s = s2_r[3];
    wire si_s = s2_r[2];
    wire hold_n_s = s2_r[1];
    wire wp_s = s2_r[0];
    wire sck_rise = sck_s & ~sck_d_r;
    wire sck_fall = ~sck_s & sck_d_r;
    wire quad_mode = cfg_in[sfph_pkg::SFPH_CFG_QUAD_BIT];
    wire prot_start = cfg_in[sfph_pkg::SFPH_CFG_PROT_START_BIT];

    // ----------------------------------------------------------------
    // hold mode
    // ----------------------------------------------------------------
    logic hold_r, hold_nxt;
    // change at once while clock is low, else at next falling edge
    always_comb begin
        hold_nxt = hold_r;
        if (quad_mode || cs_n_s) begin
            hold_nxt = 1'b0;
        end else if (hold_n_s == hold_r && (!sck_s || sck_fall)) begin
            hold_nxt = ~hold_n_s;
        end
    end
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            hold_r <= 1'b0;
        end else begin
            hold_r <= hold_nxt;
        end
    end
    assign hold_active = hold_r;
    // the block shifts nothing out; output stays floating, disabled under hold too
    assign so_out = 1'b0;
    assign so_oe = 1'b0;

    // ----------------------------------------------------------------
    // serial front end
    // ----------------------------------------------------------------
    sfph_pkg::sfph_phase_t phase_r;
    logic [7:0] shift_r;
    logic [2:0] bit_r;
    logic [1:0] abyte_r;
    logic [7:0] op_r;
    logic [22:0] addr_r;
    logic [7:0] data_r;
    logic got_data_r;
    // serial clock ignored during hold, so no bit is counted
    wire take = sck_rise & ~cs_n_s & ~hold_r;
    wire [7:0] byte_in = {shift_r[6:0], si_s};
    wire byte_done = take && (bit_r == sfph_pkg::SFPH_BIT_LAST);
    wire needs_addr = (op_r == sfph_pkg::SFPH_OP_PAGE_PROGRAM) || (op_r == sfph_pkg::SFPH_OP_QUAD_PAGE_PROGRAM)
        || (op_r == sfph_pkg::SFPH_OP_SECTOR_ERASE) || (op_r == sfph_pkg::SFPH_OP_PARAM_SMALL_ERASE)
        || (op_r == sfph_pkg::SFPH_OP_PARAM_DOUBLE_ERASE) || (op_r == sfph_pkg::SFPH_OP_OTP_BYTE_PROGRAM);
    wire is_modify = needs_addr || (op_r == sfph_pkg::SFPH_OP_BULK_ERASE)
        || (op_r == sfph_pkg::SFPH_OP_REGISTER_WRITE);
    wire is_array = needs_addr || (op_r == sfph_pkg::SFPH_OP_BULK_ERASE);
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            phase_r <= sfph_pkg::SFPH_OPCODE;
            shift_r <= 8'h00;
            bit_r <= 3'h0;
            abyte_r <= 2'h0;
            op_r <= 8'h00;
            addr_r <= 23'h000000;
            data_r <= 8'h00;
            got_data_r <= 1'b0;
        end else if (cs_n_s) begin
            phase_r <= sfph_pkg::SFPH_OPCODE;
            bit_r <= 3'h0;
            abyte_r <= 2'h0;
            got_data_r <= 1'b0;
        end else if (take) begin
            shift_r <= byte_in;
            bit_r <= bit_r + 3'h1;
            if (byte_done) begin
                case (phase_r)
                    sfph_pkg::SFPH_OPCODE: begin
                        op_r <= byte_in;
                        phase_r <= sfph_pkg::SFPH_ADDRESS;
                    end
                    sfph_pkg::SFPH_ADDRESS: begin
                        if (needs_addr && abyte_r != 2'h3) begin
                            addr_r <= {addr_r[14:0], byte_in};
                            abyte_r <= abyte_r + 2'h1;
                        end else begin
                            data_r <= byte_in;
                            got_data_r <= 1'b1;
                            phase_r <= sfph_pkg::SFPH_PAYLOAD;
                        end
                    end
                    sfph_pkg::SFPH_PAYLOAD: begin
                        if (!got_data_r) begin
                            data_r <= byte_in;
                        end
                        got_data_r <= 1'b1;
                    end
                    default: begin
                        phase_r <= sfph_pkg::SFPH_DONE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // command completion at deselect
    // ----------------------------------------------------------------
    logic cs_n_d_r;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cs_n_d_r <= 1'b1;
        end else begin
            cs_n_d_r <= cs_n_s;
        end
    end
    wire cs_rise = cs_n_s & ~cs_n_d_r;
    wire op_seen = (phase_r != sfph_pkg::SFPH_OPCODE);
    // a deselect inside hold aborts the command instead of finishing it
    wire ended = cs_rise & op_seen & ~hold_r;
    wire whole_bytes = (bit_r == 3'h0);
    wire addr_ok = !needs_addr || (abyte_r == 2'h3);
    wire [6:0] sector = addr_r[22:16];
    logic sector_prot;
    sfph_protect_map u_map (
        .block_protect(block_protect),
        .protect_start_select(prot_start),
        .sector(sector),
        .is_protected(sector_prot)
    );
    wire bulk_blocked = (op_r == sfph_pkg::SFPH_OP_BULK_ERASE) && (block_protect != sfph_pkg::SFPH_BP_NONE);
    wire area_blocked = (needs_addr && sector_prot) || bulk_blocked;
    wire go = ended && is_modify && whole_bytes && addr_ok
        && write_enable_latch && !engine_busy
        && !(is_array && area_blocked);
    wire wr_reg = go && (op_r == sfph_pkg::SFPH_OP_REGISTER_WRITE) && got_data_r;
    wire hw_mode = status_write_disable & ~wp_s & ~quad_mode;
    assign hardware_protection_mode = hw_mode;

    // ----------------------------------------------------------------
    // latch, status bits and execute strobe
    // ----------------------------------------------------------------
    logic wel_r, wel_nxt;
    logic swd_r;
    logic [2:0] bp_r;
    always_comb begin
        wel_nxt = wel_r;
        if (ended && whole_bytes && op_r == sfph_pkg::SFPH_OP_WRITE_ENABLE) begin
            wel_nxt = 1'b1;
        end else if (go || (ended && whole_bytes && op_r == sfph_pkg::SFPH_OP_WRITE_DISABLE)) begin
            wel_nxt = 1'b0;
        end
    end
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wel_r <= 1'b0;
            swd_r <= sfph_pkg::SFPH_ST_RESET[sfph_pkg::SFPH_ST_SWD_BIT];
            bp_r <= sfph_pkg::SFPH_ST_RESET[sfph_pkg::SFPH_ST_BP_LSB +: 3];
            exec_valid <= 1'b0;
            exec_opcode <= 8'h00;
            exec_addr <= 23'h000000;
            cmd_rejected <= 1'b0;
        end else begin
            wel_r <= wel_nxt;
            // hardware mode leaves the lock and protect bits untouched
            if (wr_reg && !hw_mode) begin
                swd_r <= data_r[sfph_pkg::SFPH_ST_SWD_BIT];
                bp_r <= data_r[sfph_pkg::SFPH_ST_BP_LSB +: 3];
            end
            exec_valid <= go;
            exec_opcode <= op_r;
            exec_addr <= addr_r;
            cmd_rejected <= ended && is_modify && !go;
        end
    end
    assign write_enable_latch = wel_r;
    assign status_write_disable = swd_r;
    assign block_protect = bp_r;
endmodule

// ==== tb/sfph_core_sva.sv ====
/* checker for sfph_core: timing relations between its ports.
   assumes one clock domain, bound to every sfph_core instance. */
`timescale 1ns/1ps
module sfph_core_sva (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic [7:0] cfg_in,
    input wire logic so_oe,
    input wire logic write_enable_latch,
    input wire logic status_write_disable,
    input wire logic [2:0] block_protect,
    input wire logic hardware_protection_mode,
    input wire logic hold_active,
    input wire logic exec_valid,
    input wire logic cmd_rejected
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    property p_out_float;
        !so_oe;
    endproperty
    a_out_float: assert property (p_out_float) else $error("serial output enabled");
    property p_exec_latch;
        exec_valid |-> (write_enable_latch || $past(write_enable_latch));
    endproperty
    a_exec_latch: assert property (p_exec_latch) else $error("execute without latch");
    property p_latch_clear;
        exec_valid |-> ##[0:2] !write_enable_latch;
    endproperty
    a_latch_clear: assert property (p_latch_clear) else $error("latch kept after execute");
    property p_one_verdict;
        !(exec_valid && cmd_rejected);
    endproperty
    a_one_verdict: assert property (p_one_verdict) else $error("execute and refuse together");
    property p_reject_pulse;
        cmd_rejected |=> !cmd_rejected;
    endproperty
    a_reject_pulse: assert property (p_reject_pulse) else $error("refuse pulse too long");
    property p_hw_mode;
        hardware_protection_mode |-> status_write_disable && !cfg_in[sfph_pkg::SFPH_CFG_QUAD_BIT];
    endproperty
    a_hw_mode: assert property (p_hw_mode) else $error("hardware mode without cause");
    property p_hw_freeze;
        hardware_protection_mode && $past(hardware_protection_mode) |-> $stable(block_protect) && $stable(status_write_disable);
    endproperty
    a_hw_freeze: assert property (p_hw_freeze) else $error("locked bits changed");
    property p_quad_no_hold;
        cfg_in[sfph_pkg::SFPH_CFG_QUAD_BIT] [*3] |-> !hold_active;
    endproperty
    a_quad_no_hold: assert property (p_quad_no_hold) else $error("hold in quad mode");
    property p_deselect_hold;
        hold_active && $rose(cs_n) |-> ##[0:4] !hold_active;
    endproperty
    a_deselect_hold: assert property (p_deselect_hold) else $error("hold kept after deselect");
endmodule
bind sfph_core sfph_core_sva u_sva (.core_clk(core_clk), .reset(reset), .cs_n(cs_n), .cfg_in(cfg_in),
    .so_oe(so_oe), .write_enable_latch(write_enable_latch), .status_write_disable(status_write_disable),
    .block_protect(block_protect), .hardware_protection_mode(hardware_protection_mode),
    .hold_active(hold_active), .exec_valid(exec_valid), .cmd_rejected(cmd_rejected));

// ==== tb/sfph_host_model.sv ====
/* host bus master model: mode 0 frames, 80 ns bit period.
   assumes the bench calls its tasks one at a time. */
`timescale 1ns/1ps
module sfph_host_model (
    input wire logic core_clk,
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic hold_n,
    output logic write_protect_pin
);
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
        write_protect_pin = 1'b1;
    end
    task automatic sel(input logic v);
        repeat (10) @(negedge core_clk);
        cs_n = v;
        // idle data flips so a stale level is never trusted
        if (v) si = ~si;
        repeat (10) @(negedge core_clk);
    endtask
    task automatic bits(input logic [47:0] d, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            si = d[i];
            repeat (10) @(negedge core_clk);
            sck = 1'b1;
            repeat (10) @(negedge core_clk);
            sck = 1'b0;
        end
    endtask
    // only moved with sck low; raised before any new select
    task automatic hold(input logic v);
        repeat (10) @(negedge core_clk);
        hold_n = v;
        repeat (10) @(negedge core_clk);
    endtask
endmodule

// ==== tb/sfph_core_test.sv ====
/* self-checking bench for sfph_core with the host model.
   assumes the checker is bound in by its own file. */
`timescale 1ns/1ps
`define CHECK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; $display("ERROR %0t: got %h want %h", $time, g, e); end end
module sfph_core_test;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] cfg_in = 8'h00;
    logic engine_busy = 1'b0;
    logic cs_n, sck, si, hold_n, write_protect_pin, so_out, so_oe, write_enable_latch, status_write_disable;
    logic hardware_protection_mode, hold_active, exec_valid, cmd_rejected;
    logic [2:0] block_protect;
    logic [7:0] exec_opcode;
    logic [22:0] exec_addr;
    int fail_count = 0;
    int samples_checked = 0;
    int n_exec = 0;
    int n_rej = 0;
    always #2 core_clk = ~core_clk;
    sfph_core DUT (.core_clk(core_clk), .reset(reset), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
        .write_protect_pin(write_protect_pin), .cfg_in(cfg_in), .engine_busy(engine_busy), .so_out(so_out),
        .so_oe(so_oe), .write_enable_latch(write_enable_latch), .status_write_disable(status_write_disable),
        .block_protect(block_protect), .hardware_protection_mode(hardware_protection_mode),
        .hold_active(hold_active), .exec_valid(exec_valid), .exec_opcode(exec_opcode), .exec_addr(exec_addr),
        .cmd_rejected(cmd_rejected));
    sfph_host_model host (.core_clk(core_clk), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
        .write_protect_pin(write_protect_pin));
    // pulses are counted mid-cycle, where they are settled
    always @(negedge core_clk) begin
        if (exec_valid === 1'b1) n_exec++;
        if (cmd_rejected === 1'b1) n_rej++;
    end
    task automatic cmd(input logic [47:0] d, input int n);
        host.sel(1'b0);
        host.bits(d, n);
        host.sel(1'b1);
    endtask
    task automatic register_write_cmd(input logic [7:0] st);
        cmd(48'h06, 8);
        cmd({8'h01, st}, 16);
    endtask
    // one program attempt; ok says whether it may execute
    task automatic prog(input logic [23:0] a, input logic ok, input int n);
        int e;
        int r;
        e = n_exec;
        r = n_rej;
        cmd({8'h02, a, 8'h5A}, n);
        `CHECK(n_exec - e, int'(ok))
        `CHECK(n_rej - r, int'(!ok))
        if (ok) begin
            `CHECK(exec_addr, a[22:0])
            `CHECK(exec_opcode, sfph_pkg::SFPH_OP_PAGE_PROGRAM)
        end
    endtask
    task automatic t_latch();
        cmd(48'h06, 8);
        `CHECK(write_enable_latch, 1'b1)
        cmd(48'h04, 8);
        `CHECK(write_enable_latch, 1'b0)
        prog(24'h000100, 1'b0, 40);
        cmd(48'h06, 8);
        prog(24'h000100, 1'b0, 41);
        // a busy array engine refuses new work; a refused command keeps the latch
        engine_busy = 1'b1;
        prog(24'h000100, 1'b0, 40);
        engine_busy = 1'b0;
        `CHECK(write_enable_latch, 1'b1)
        $display("test latch done");
    endtask
    task automatic t_protect();
        logic [28:0] tbl [8] = '{{1'b0, 3'h1, 24'h7E0000, 1'b0}, {1'b0, 3'h1, 24'h7DFFFF, 1'b1},
            {1'b1, 3'h1, 24'h01FFFF, 1'b0}, {1'b1, 3'h1, 24'h020000, 1'b1}, {1'b0, 3'h7, 24'h000000, 1'b0},
            {1'b1, 3'h6, 24'h3FFFFF, 1'b0}, {1'b1, 3'h6, 24'h400000, 1'b1}, {1'b0, 3'h0, 24'h7F0000, 1'b1}};
        foreach (tbl[i]) begin
            // unused config bits set high to show they change nothing
            cfg_in = {2'h3, tbl[i][28], 5'h1D};
            register_write_cmd({3'h0, tbl[i][27:25], 2'h0});
            `CHECK(block_protect, tbl[i][27:25])
            cmd(48'h06, 8);
            prog(tbl[i][24:1], tbl[i][0], 40);
            // only a completed command clears the latch; a refused one leaves it set
            `CHECK(write_enable_latch, !tbl[i][0])
        end
        $display("test protect done");
    endtask
    task automatic t_hw();
        host.write_protect_pin = 1'b0;
        register_write_cmd(8'h84);
        `CHECK(hardware_protection_mode, 1'b1)
        register_write_cmd(8'h00);
        `CHECK({status_write_disable, block_protect}, 4'h9)
        host.write_protect_pin = 1'b1;
        register_write_cmd(8'h00);
        `CHECK({hardware_protection_mode, status_write_disable}, 2'h0)
        $display("test hw done");
    endtask
    task automatic t_hold();
        host.sel(1'b0);
        host.bits(48'h0, 4);
        host.hold(1'b0);
        `CHECK({hold_active, so_oe, so_out}, 3'h4)
        host.bits(48'hF, 4);
        host.hold(1'b1);
        `CHECK(hold_active, 1'b0)
        host.bits(48'h6, 4);
        host.sel(1'b1);
        `CHECK(write_enable_latch, 1'b1)
        cmd(48'h04, 8);
        host.sel(1'b0);
        host.bits(48'h06, 8);
        host.hold(1'b0);
        host.sel(1'b1);
        `CHECK({hold_active, write_enable_latch}, 2'h0)
        host.hold(1'b1);
        cfg_in[1] = 1'b1;
        host.sel(1'b0);
        host.hold(1'b0);
        `CHECK(hold_active, 1'b0)
        host.hold(1'b1);
        host.sel(1'b1);
        cfg_in[1] = 1'b0;
        $display("test hold done");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge core_clk);
        reset = 1'b0;
        repeat (4) @(negedge core_clk);
        t_latch();
        t_protect();
        t_hw();
        t_hold();
        give_verdict();
    end
    initial begin
        repeat (90000) @(posedge core_clk);
        fail_count++;
        $display("ERROR %0t: run did not finish", $time);
        give_verdict();
    end
endmodule
